// ---- logic/tsc_top.sv ----
// control, status and conversion-rate logic of the temperature sensor
// assumes a same-clock converter answering each start with one done pulse
`timescale 1ns/1ns
module tsc_top #(
	parameter int unsigned P_SLOW_CYCLES = tsc_pkg::SLOW_CYCLES
) (
	// core clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// register command port, link domain
	input wire logic i_link_clk,
	input wire logic i_req_valid,
	input wire tsc_pkg::tsc_req_s i_req,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	// converter
	output logic o_conv_start,
	output logic o_conv_remote,
	input wire logic i_conv_done,
	input wire tsc_pkg::tsc_cmp_s i_conv_cmp,
	// alarm pins
	output logic o_alert_n,
	output logic o_critical_out_n
);
	import tsc_pkg::*;

	tsc_state_e state_r;
	tsc_state_e state_nxt;
	logic [7:0] cfg_r;
	logic [3:0] rate_r;
	logic [6:0] flags_r;
	logic [6:0] flags_nxt;
	logic [31:0] tick_r;
	logic remote_next_r;
	logic oneshot_pend_r;
	logic req_tog_link;
	tsc_req_s req_hold_link;
	logic req_tog_sync;
	logic req_tog_seen_r;
	logic ack_tog_r;
	logic [7:0] rdata_r;
	logic [2:0] rem_hit;
	logic [2:0] rem_declare;

	// link side and crossing
	tsc_link u_link (
		.i_link_clk(i_link_clk),
		.i_resetn(i_resetn),
		.i_req_valid(i_req_valid),
		.i_req(i_req),
		.o_req_ready(o_req_ready),
		.o_rsp_valid(o_rsp_valid),
		.o_rsp_data(o_rsp_data),
		.o_req_tog(req_tog_link),
		.o_req_hold(req_hold_link),
		.i_ack_tog(ack_tog_r),
		.i_rsp_byte(rdata_r)
	);

	tsc_sync #(.P_WIDTH(1)) u_req_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_async(req_tog_link),
		.o_sync(req_tog_sync)
	);

	// request decode; hold is stable once the toggle has crossed
	wire req_fire = req_tog_sync ^ req_tog_seen_r;
	wire wr_fire = req_fire & req_hold_link.wr;
	wire rd_fire = req_fire & ~req_hold_link.wr;
	wire [7:0] req_cmd = req_hold_link.cmd;
	wire cfg_wr = wr_fire & (req_cmd == CMD_CFG_WR);
	wire rate_wr = wr_fire & (req_cmd == CMD_RATE_WR);
	wire oneshot_wr = wr_fire & (req_cmd == CMD_ONESHOT) & cfg_r[CFG_STANDBY];

	// status byte and read selection
	wire busy = (state_r == ST_CONV);
	wire [7:0] status = {busy, flags_r}; // [RULE10]
	wire [7:0] cfg_view = cfg_r & CFG_WMASK; // [RULE5]
	wire [7:0] rd_byte = (req_cmd == CMD_STATUS_RD) ? status : // [RULE8]
		(req_cmd == CMD_CFG_RD) ? cfg_view : // [RULE19]
		(req_cmd == CMD_RATE_RD) ? {4'h0, rate_r} : // [RULE16]
		(req_cmd == CMD_ONESHOT) ? ONESHOT_READBACK : // [RULE21]
		UNMAPPED_READBACK;

	// conversion scheduling
	wire [3:0] rate_eff = (rate_r > RATE_MAX) ? RATE_MAX : rate_r; // [RULE20]
	wire [31:0] interval = 32'(P_SLOW_CYCLES >> rate_eff) - 32'h1; // [RULE18]
	wire run_mode = ~cfg_r[CFG_STANDBY];
	wire periodic_due = run_mode & (tick_r == 32'h0);
	wire start_conv = (state_r == ST_IDLE) & (periodic_due | oneshot_pend_r); // [RULE2]
	wire done_ok = i_conv_done & busy;
	wire done_local = done_ok & ~o_conv_remote;
	wire done_remote = done_ok & o_conv_remote;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start_conv) begin
					state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (i_conv_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// remote fault queue: over, under, critical
	assign rem_hit = {i_conv_cmp.crit, i_conv_cmp.under, i_conv_cmp.over};

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_queue
			logic [1:0] cnt_r;
			wire [1:0] cnt_nxt = (cnt_r == QUEUE_PRIOR) ? cnt_r : cnt_r + 2'h1;

			assign rem_declare[k] = rem_hit[k] &
				(~cfg_r[CFG_QUEUE] | (cnt_r == QUEUE_PRIOR)); // [RULE6] [RULE7]

			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					cnt_r <= 2'h0;
				end else if (done_remote) begin
					cnt_r <= rem_hit[k] ? cnt_nxt : 2'h0; // [RULE7]
				end
			end
		end
	endgenerate

	// flags follow the latest comparison of their channel; remote over, under and critical go through the fault queue
	assign flags_nxt[SB_LOVER] = done_local ? i_conv_cmp.over : flags_r[SB_LOVER]; // [RULE11]
	assign flags_nxt[SB_LUNDER] = done_local ? i_conv_cmp.under : flags_r[SB_LUNDER]; // [RULE11]
	assign flags_nxt[SB_LOCAL_CRITICAL_FLAG] = done_local ? i_conv_cmp.crit : flags_r[SB_LOCAL_CRITICAL_FLAG]; // [RULE14]
	assign flags_nxt[SB_ROVER] = done_remote ? rem_declare[0] : flags_r[SB_ROVER]; // [RULE12]
	assign flags_nxt[SB_RUNDER] = done_remote ? rem_declare[1] : flags_r[SB_RUNDER]; // [RULE12]
	assign flags_nxt[SB_REMOTE_CRITICAL_FLAG] = done_remote ? rem_declare[2] : flags_r[SB_REMOTE_CRITICAL_FLAG]; // [RULE14]
	assign flags_nxt[SB_OPEN] = done_remote ? i_conv_cmp.open : flags_r[SB_OPEN]; // [RULE13]

	// pin drive
	wire alert_nxt_n = ~((|(status & ALERT_SRC_MASK)) & ~cfg_r[CFG_ALERT_MASK]); // [RULE1] [RULE9]
	wire remote_critical_flag_on = flags_r[SB_REMOTE_CRITICAL_FLAG] & ~cfg_r[CFG_REMOTE_CRITICAL_FLAG_MASK]; // [RULE3]
	wire local_critical_flag_on = flags_r[SB_LOCAL_CRITICAL_FLAG] & ~cfg_r[CFG_LOCAL_CRITICAL_FLAG_MASK]; // [RULE4]
	wire crit_nxt_n = ~(remote_critical_flag_on | local_critical_flag_on);

	// registers reached over the command port
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_r <= CFG_RESET; // [RULE5]
			rate_r <= RATE_RESET; // [RULE17]
		end else begin
			if (cfg_wr) begin
				cfg_r <= req_hold_link.data & CFG_WMASK; // [RULE5] [RULE19]
			end
			if (rate_wr) begin
				rate_r <= req_hold_link.data[3:0]; // [RULE16]
			end
		end
	end

	// answer path back to the link
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			req_tog_seen_r <= 1'b0;
			ack_tog_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			req_tog_seen_r <= req_tog_sync;
			if (req_fire) begin
				ack_tog_r <= ~ack_tog_r;
			end
			if (rd_fire) begin
				rdata_r <= rd_byte;
			end
		end
	end

	// sequencer, alternating channels
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= ST_IDLE;
			tick_r <= 32'h0;
			remote_next_r <= 1'b0;
			oneshot_pend_r <= 1'b0;
			o_conv_start <= 1'b0;
			o_conv_remote <= 1'b0;
		end else begin
			state_r <= state_nxt;
			o_conv_start <= start_conv;
			if (start_conv) begin
				tick_r <= interval; // [RULE18]
				o_conv_remote <= remote_next_r;
				remote_next_r <= ~remote_next_r; // [RULE22]
			end else if (tick_r != 32'h0) begin
				tick_r <= tick_r - 32'h1;
			end
			if (oneshot_wr) begin
				oneshot_pend_r <= 1'b1; // [RULE21]
			end else if (start_conv) begin
				oneshot_pend_r <= 1'b0;
			end
		end
	end

	// flags and pins
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flags_r <= FLAGS_RESET; // [RULE8]
			o_alert_n <= 1'b1;
			o_critical_out_n <= 1'b1;
		end else begin
			flags_r <= flags_nxt; // [RULE22]
			o_alert_n <= alert_nxt_n;
			o_critical_out_n <= crit_nxt_n;
		end
	end

	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	sequence s_conv_begin;
		start_conv;
	endsequence

	sequence s_conv_busy;
		o_conv_start && status[SB_BUSY];
	endsequence

	sequence s_conv_end;
		done_ok;
	endsequence

	sequence s_back_idle;
		!busy && !o_conv_start;
	endsequence

	sequence s_req_seen;
		req_fire;
	endsequence

	sequence s_ack_sent;
		ack_tog_r != $past(ack_tog_r);
	endsequence

	// conversion pacing and channel order
	a_standby_halt: assert property ( // [RULE2]
		start_conv && cfg_r[CFG_STANDBY] |-> oneshot_pend_r)
		else $error("periodic conversion in standby");
	a_run_start: assert property ( // [RULE2]
		state_r == ST_IDLE && run_mode && tick_r == 32'h0 |=> o_conv_start)
		else $error("free run start missed");
	a_busy_flag: assert property ( // [RULE10]
		s_conv_begin |=> s_conv_busy)
		else $error("busy flag not shown during conversion");
	a_busy_clear: assert property ( // [RULE10]
		s_conv_end |=> s_back_idle)
		else $error("busy flag stuck after conversion");
	a_alternate: assert property ( // [RULE22]
		start_conv |=> o_conv_remote == $past(remote_next_r) && remote_next_r == !o_conv_remote)
		else $error("channel did not alternate");
	a_interval: assert property ( // [RULE18]
		start_conv |=> tick_r == 32'(P_SLOW_CYCLES >> $past(rate_eff)) - 32'h1)
		else $error("interval not loaded from rate code");
	a_tick_count: assert property ( // [RULE18]
		!start_conv && tick_r != 32'h0 |=> tick_r == $past(tick_r) - 32'h1)
		else $error("interval counter skipped a step");
	a_oneshot_start: assert property ( // [RULE21]
		oneshot_wr && !oneshot_pend_r && state_r == ST_IDLE |=> start_conv)
		else $error("one-shot did not start a conversion");
	a_oneshot_once: assert property ( // [RULE21]
		start_conv && cfg_r[CFG_STANDBY] && !oneshot_wr |=> !oneshot_pend_r)
		else $error("one-shot request left pending");
	a_oneshot_readback: assert property ( // [RULE21]
		rd_fire && req_cmd == CMD_ONESHOT |=> rdata_r == ONESHOT_READBACK)
		else $error("one-shot code did not read ff");
	// flags
	a_local_flags: assert property ( // [RULE11] [RULE14]
		done_local |=> flags_r[SB_LOVER] == $past(i_conv_cmp.over)
			&& flags_r[SB_LUNDER] == $past(i_conv_cmp.under)
			&& flags_r[SB_LOCAL_CRITICAL_FLAG] == $past(i_conv_cmp.crit))
		else $error("local flags not taken from comparison");
	a_open_flag: assert property ( // [RULE13]
		done_remote |=> flags_r[SB_OPEN] == $past(i_conv_cmp.open))
		else $error("open diode flag not taken");
	a_queue_single: assert property ( // [RULE6]
		done_remote && i_conv_cmp.over && !cfg_r[CFG_QUEUE] |=> flags_r[SB_ROVER])
		else $error("single remote fault not flagged");
	a_remote_under: assert property ( // [RULE6] [RULE12]
		done_remote && i_conv_cmp.under && !cfg_r[CFG_QUEUE] |=> flags_r[SB_RUNDER])
		else $error("single remote under fault not flagged");
	a_queue_first: assert property ( // [RULE7]
		done_remote && i_conv_cmp.over && cfg_r[CFG_QUEUE] && g_queue[0].cnt_r == 2'h0
			|=> !flags_r[SB_ROVER])
		else $error("fault declared before three readings");
	a_queue_third: assert property ( // [RULE7]
		done_remote && i_conv_cmp.over && g_queue[0].cnt_r == QUEUE_PRIOR |=> flags_r[SB_ROVER])
		else $error("third remote fault not declared");
	a_queue_clear: assert property ( // [RULE7]
		done_remote && !i_conv_cmp.over |=> !flags_r[SB_ROVER] && g_queue[0].cnt_r == 2'h0)
		else $error("fault queue not restarted");
	// pins
	a_alert_masked: assert property ( // [RULE1]
		cfg_r[CFG_ALERT_MASK] |=> o_alert_n)
		else $error("alert driven while masked");
	a_alert_cause: assert property ( // [RULE9]
		(|(flags_r & ALERT_SRC_MASK[6:0])) && !cfg_r[CFG_ALERT_MASK] |=> !o_alert_n)
		else $error("alert not raised for a flag");
	a_alert_exempt: assert property ( // [RULE9]
		(flags_r & ALERT_SRC_MASK[6:0]) == 7'h00 |=> o_alert_n)
		else $error("alert raised by busy or open only");
	a_remote_crit_pin: assert property ( // [RULE3]
		flags_r[SB_REMOTE_CRITICAL_FLAG] && !cfg_r[CFG_REMOTE_CRITICAL_FLAG_MASK] |=> !o_critical_out_n)
		else $error("remote critical did not drive pin");
	a_local_crit_pin: assert property ( // [RULE4]
		flags_r[SB_LOCAL_CRITICAL_FLAG] && !cfg_r[CFG_LOCAL_CRITICAL_FLAG_MASK] |=> !o_critical_out_n)
		else $error("local critical did not drive pin");
	a_crit_masked: assert property ( // [RULE3] [RULE4]
		(!flags_r[SB_REMOTE_CRITICAL_FLAG] || cfg_r[CFG_REMOTE_CRITICAL_FLAG_MASK])
			&& (!flags_r[SB_LOCAL_CRITICAL_FLAG] || cfg_r[CFG_LOCAL_CRITICAL_FLAG_MASK]) |=> o_critical_out_n)
		else $error("critical pin driven while masked");
	// register port
	a_req_ack: assert property ( // [RULE19]
		s_req_seen |=> s_ack_sent)
		else $error("request not acknowledged");
	a_ack_only: assert property ( // [RULE19]
		!req_fire |=> ack_tog_r == $past(ack_tog_r))
		else $error("acknowledge without request");
	a_status_read: assert property ( // [RULE8]
		rd_fire && req_cmd == CMD_STATUS_RD |=> rdata_r == $past(status))
		else $error("status read returned wrong byte");
	a_status_ro: assert property ( // [RULE8]
		wr_fire && req_cmd == CMD_STATUS_RD |=> cfg_r == $past(cfg_r) && rate_r == $past(rate_r))
		else $error("write to status code changed a register");
	a_cfg_reserved_zero: assert property ( // [RULE5]
		cfg_r[5] == 1'b0 && cfg_r[3] == 1'b0 && cfg_r[1] == 1'b0)
		else $error("reserved config bits stored");
	a_cfg_read_zero: assert property ( // [RULE5]
		rd_fire && req_cmd == CMD_CFG_RD
			|=> rdata_r[5] == 1'b0 && rdata_r[3] == 1'b0 && rdata_r[1] == 1'b0)
		else $error("reserved config bits read nonzero");
	a_cfg_write: assert property ( // [RULE19]
		cfg_wr |=> cfg_r == ($past(req_hold_link.data) & CFG_WMASK))
		else $error("config write not stored");
	a_rate_write: assert property ( // [RULE16]
		rate_wr |=> rate_r == $past(req_hold_link.data[3:0]))
		else $error("rate write not stored");
	a_rate_reserved: assert property ( // [RULE16]
		rd_fire && req_cmd == CMD_RATE_RD |=> rdata_r[7:4] == 4'h0)
		else $error("rate upper bits read nonzero");
endmodule

// ---- logic/tsc_pkg.sv ----
// register map, field layout, reset values and timing of the
// temperature sensor control and status block
// assumes a 25 MHz core clock; the converter lives outside
// How it works
// RULE1: config bit 7 set suppresses the alert output; clear lets alarms drive it.
// RULE2: config bit 6 set halts periodic conversion; clear converts continuously.
// RULE3: config bit 4 clear lets a remote critical reading assert the critical output.
// RULE4: config bit 2 clear lets a local critical reading assert the critical output.
// RULE5: config bits 5, 3, 1 read zero; all config bits reset to zero.
// RULE6: fault queue off: one remote out-of-limit reading sets flags and pins at once.
// RULE7: fault queue on: three successive remote readings beyond one threshold are needed.
// RULE8: status byte is read-only at code 02h and resets to all zero.
// RULE9: any status flag except busy and open diode raises the alert.
// RULE10: status bit 7 reads one while a conversion is running.
// RULE11: status bit 6 is local over high limit, bit 5 local under low limit.
// RULE12: status bit 4 is remote over high limit, bit 3 remote under low limit.
// RULE13: status bit 2 flags a disconnected remote sensing diode.
// RULE14: status bit 1 is remote critical alarm, bit 0 local critical alarm.
// RULE15: host waits about one conversion period, 38 ms, after one-shot before reading status.
// RULE16: rate register keeps four low bits; read at 04h, written at 0Ah.
// RULE17: rate register resets to 08h, about sixteen conversions per second.
// RULE18: in free run the conversion interval follows the rate code, halving per step.
// RULE19: config register is read at code 03h and written at code 09h.
// RULE20: host writes only rate codes 00h to 09h; higher codes are undefined.
// RULE21: write to 0Fh in standby runs one conversion; 0Fh reads back FFh.
// RULE22: running mode alternates local and remote, comparing at each conversion end.
package tsc_pkg;
	// command codes
	localparam logic [7:0] CMD_STATUS_RD = 8'h02;
	localparam logic [7:0] CMD_CFG_RD = 8'h03;
	localparam logic [7:0] CMD_RATE_RD = 8'h04;
	localparam logic [7:0] CMD_CFG_WR = 8'h09;
	localparam logic [7:0] CMD_RATE_WR = 8'h0a;
	localparam logic [7:0] CMD_ONESHOT = 8'h0f;
	localparam logic [7:0] ONESHOT_READBACK = 8'hff;
	localparam logic [7:0] UNMAPPED_READBACK = 8'h00;
	// config fields
	localparam int CFG_ALERT_MASK = 7;
	localparam int CFG_STANDBY = 6;
	localparam int CFG_REMOTE_CRITICAL_FLAG_MASK = 4;
	localparam int CFG_LOCAL_CRITICAL_FLAG_MASK = 2;
	localparam int CFG_QUEUE = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'hd5;
	// status fields
	localparam int SB_BUSY = 7;
	localparam int SB_LOVER = 6;
	localparam int SB_LUNDER = 5;
	localparam int SB_ROVER = 4;
	localparam int SB_RUNDER = 3;
	localparam int SB_OPEN = 2;
	localparam int SB_REMOTE_CRITICAL_FLAG = 1;
	localparam int SB_LOCAL_CRITICAL_FLAG = 0;
	localparam logic [6:0] FLAGS_RESET = 7'h00;
	localparam logic [7:0] ALERT_SRC_MASK = 8'h7b;
	// rate register
	localparam logic [3:0] RATE_RESET = 4'h8;
	localparam logic [3:0] RATE_MAX = 4'h9;
	// fault queue: earlier consecutive hits needed before the current one
	localparam logic [1:0] QUEUE_PRIOR = 2'h2;
	// timing: slowest interval is code 00h, about 0.0625 Hz
	localparam int unsigned CLK_KHZ = 25000;
	localparam int unsigned SLOW_PERIOD_MS = 16000;
	localparam int unsigned SLOW_CYCLES = SLOW_PERIOD_MS * CLK_KHZ;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} tsc_state_e;

	typedef struct packed {
		logic wr;
		logic [7:0] cmd;
		logic [7:0] data;
	} tsc_req_s;

	typedef struct packed {
		logic over;
		logic under;
		logic crit;
		logic open;
	} tsc_cmp_s;
endpackage

// ---- logic/tsc_sync.sv ----
// two-flop level synchroniser
// assumes the input is a level held long enough to be seen
`timescale 1ns/1ns
module tsc_sync #(
	parameter int P_WIDTH = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// level in and out
	input wire logic [P_WIDTH-1:0] i_async,
	output logic [P_WIDTH-1:0] o_sync
);
	logic [P_WIDTH-1:0] meta_r;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule

// ---- logic/tsc_link.sv ----
// link-clock side of the register command port
// assumes one request outstanding; the core answers by toggling ack
`timescale 1ns/1ns
module tsc_link (
	// link clock and reset
	input wire logic i_link_clk,
	input wire logic i_resetn,
	// command port
	input wire logic i_req_valid,
	input wire tsc_pkg::tsc_req_s i_req,
	output logic o_req_ready,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	// crossing to core
	output logic o_req_tog,
	output tsc_pkg::tsc_req_s o_req_hold,
	input wire logic i_ack_tog,
	input wire logic [7:0] i_rsp_byte
);
	import tsc_pkg::*;

	logic ack_sync;
	logic ack_seen_r;
	wire take = i_req_valid & o_req_ready;
	wire ack_fire = ack_sync ^ ack_seen_r;

	tsc_sync #(.P_WIDTH(1)) u_ack_sync (
		.i_clk(i_link_clk),
		.i_resetn(i_resetn),
		.i_async(i_ack_tog),
		.o_sync(ack_sync)
	);

	// hold stays stable until the core acknowledges
	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_req_tog <= 1'b0;
			o_req_hold <= '0;
			ack_seen_r <= 1'b0;
			o_req_ready <= 1'b1;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 8'h00;
		end else begin
			o_rsp_valid <= ack_fire;
			if (take) begin
				o_req_hold <= i_req;
				o_req_tog <= ~o_req_tog;
				o_req_ready <= 1'b0;
			end
			if (ack_fire) begin
				ack_seen_r <= ack_sync;
				o_req_ready <= 1'b1;
				if (!o_req_hold.wr) begin
					o_rsp_data <= i_rsp_byte;
				end
			end
		end
	end
endmodule

// ---- bench/tsc_conv_model.sv ----
// converter stand-in: one done pulse per start after a set delay
// assumes start and channel come from core registers on i_clk
`timescale 1ns/1ns
module tsc_conv_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// from the core
	input wire logic i_start,
	input wire logic i_remote,
	// scenario settings
	input wire logic [7:0] i_delay,
	input wire tsc_pkg::tsc_cmp_s i_loc_cmp,
	input wire tsc_pkg::tsc_cmp_s i_rem_cmp,
	// to the core
	output logic o_done,
	output tsc_pkg::tsc_cmp_s o_cmp
);
	import tsc_pkg::*;
	logic busy_r;
	logic rem_r;
	logic [7:0] cnt_r;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_r <= 1'b0;
			rem_r <= 1'b0;
			cnt_r <= 8'h00;
			o_done <= 1'b0;
			o_cmp <= '0;
		end else begin
			o_done <= 1'b0;
			// result only meaningful with done, so keep it moving
			o_cmp <= ~o_cmp;
			if (i_start) begin
				busy_r <= 1'b1;
				rem_r <= i_remote;
				cnt_r <= i_delay;
			end else if (busy_r && cnt_r == 8'h00) begin
				busy_r <= 1'b0;
				o_done <= 1'b1;
				o_cmp <= rem_r ? i_rem_cmp : i_loc_cmp;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule

// ---- bench/test_temp_sensor_ctrl_status.sv ----
// self-checking bench: register port, conversion pacing, flags, pins
// assumes tsc_conv_model stands in for the converter
`timescale 1ns/1ns
module test_temp_sensor_ctrl_status;
	import tsc_pkg::*;
	localparam int unsigned SLOW = 1024;
	localparam int CONV_WAIT = 40;
	logic clk, lclk, resetn, valid, rdy, rsp_valid, start, remote, done, alert_n, crit_n, last_rem;
	tsc_req_s req;
	tsc_cmp_s cmp, loc_cmp, rem_cmp;
	logic [7:0] rsp_data, rd, delay, c;
	logic [31:0] lfsr;
	int bad_count, compares, starts, n;
	logic [7:0] pin_cfg [5] = '{8'h40, 8'hc0, 8'h54, 8'h44, 8'h50};

	tsc_top #(.P_SLOW_CYCLES(SLOW)) i_tsc_top (.i_clk(clk), .i_resetn(resetn),
		.i_link_clk(lclk), .i_req_valid(valid), .i_req(req), .o_req_ready(rdy),
		.o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_conv_start(start),
		.o_conv_remote(remote), .i_conv_done(done), .i_conv_cmp(cmp),
		.o_alert_n(alert_n), .o_critical_out_n(crit_n));
	tsc_conv_model i_tsc_conv_model (.i_clk(clk), .i_resetn(resetn), .i_start(start),
		.i_remote(remote), .i_delay(delay), .i_loc_cmp(loc_cmp), .i_rem_cmp(rem_cmp),
		.o_done(done), .o_cmp(cmp));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end

	function automatic logic [31:0] step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic exp_alert_n(input logic [7:0] cfg, input logic [7:0] st);
		return !((|(st & ALERT_SRC_MASK)) && !cfg[CFG_ALERT_MASK]);
	endfunction
	function automatic logic exp_crit_n(input logic [7:0] cfg, input logic [7:0] st);
		return !((st[SB_REMOTE_CRITICAL_FLAG] && !cfg[CFG_REMOTE_CRITICAL_FLAG_MASK]) || (st[SB_LOCAL_CRITICAL_FLAG] && !cfg[CFG_LOCAL_CRITICAL_FLAG_MASK]));
	endfunction

	task automatic complete_run();
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_up();
		bad_count++;
		complete_run();
	endtask
	// one request, held until taken, then wait for the answer pulse
	task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] data);
		int k;
		k = 0;
		@(negedge lclk);
		while (rdy !== 1'b1 && k < 50) begin
			@(negedge lclk);
			k++;
		end
		if (k == 50) give_up();
		valid = 1'b1;
		req = '{wr, cmd, data};
		@(negedge lclk);
		valid = 1'b0;
		k = 0;
		while (rsp_valid !== 1'b1 && k < 50) begin
			@(negedge lclk);
			k++;
		end
		if (k == 50) give_up();
		rd = rsp_data;
	endtask
	task automatic wait_start(output int k);
		int s0;
		s0 = starts;
		k = 0;
		while (starts == s0 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		if (k == 2000) give_up();
	endtask
	task automatic pair();
		int s0;
		repeat (2) begin
			s0 = starts;
			lfsr = step(lfsr);
			access(1'b1, CMD_ONESHOT, lfsr[7:0]);
			repeat (CONV_WAIT) @(negedge clk);
			check("oneshot starts", 8'(starts - s0), 8'h01);
		end
	endtask
	task automatic pins(input logic [7:0] cfg, input logic [7:0] st);
		repeat (4) @(negedge clk);
		check("alert pin", {7'h0, alert_n}, {7'h0, exp_alert_n(cfg, st)});
		check("critical pin", {7'h0, crit_n}, {7'h0, exp_crit_n(cfg, st)});
	endtask

	// channel order and start count seen at the converter side
	always @(posedge clk) begin
		if (start === 1'b1) begin
			check("channel", {7'h0, remote}, {7'h0, !last_rem});
			last_rem = remote;
			starts++;
		end
	end

	initial begin
		resetn = 1'b0;
		valid = 1'b0;
		req = '0;
		delay = 8'h02;
		loc_cmp = '0;
		rem_cmp = '0;
		lfsr = 32'h8f58;
		last_rem = 1'b1;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		pins(8'h00, 8'h00);
		access(1'b0, CMD_STATUS_RD, 8'h00);
		check("status reset", rd & 8'h7f, 8'h00);
		access(1'b0, CMD_CFG_RD, 8'h00);
		check("config reset", rd, CFG_RESET);
		access(1'b0, CMD_RATE_RD, 8'h00);
		check("rate reset", rd, 8'h08);
		access(1'b0, CMD_ONESHOT, 8'h00);
		check("oneshot readback", rd, 8'hff);
		access(1'b0, 8'h05, 8'h00);
		check("unmapped read", rd, UNMAPPED_READBACK);
		repeat (4) begin
			lfsr = step(lfsr);
			c = lfsr[7:0];
			access(1'b1, CMD_CFG_WR, c);
			access(1'b1, CMD_CFG_RD, ~c);
			access(1'b1, CMD_STATUS_RD, 8'hff);
			access(1'b0, CMD_CFG_RD, 8'h00);
			check("config readback", rd, c & 8'hd5);
		end
		access(1'b1, CMD_CFG_WR, 8'h00);
		for (int i = 0; i < 3; i++) begin
			lfsr = step(lfsr);
			c = (i == 0) ? 8'h03 : (i == 1) ? 8'h07 : 8'h03 + 8'(lfsr[15:0] % 5);
			access(1'b1, CMD_RATE_WR, c);
			access(1'b0, CMD_RATE_RD, 8'h00);
			check("rate readback", rd, c);
			wait_start(n);
			wait_start(n);
			wait_start(n);
			check("interval", 8'(n), 8'(SLOW >> c));
		end
		access(1'b1, CMD_CFG_WR, 8'h40);
		repeat (CONV_WAIT) @(negedge clk);
		n = starts;
		repeat (300) @(negedge clk);
		check("standby starts", 8'(starts - n), 8'h00);
		delay = 8'h3c;
		access(1'b1, CMD_ONESHOT, 8'h00);
		access(1'b0, CMD_STATUS_RD, 8'h00);
		check("busy high", {7'h0, rd[7]}, 8'h01);
		repeat (80) @(negedge clk);
		access(1'b0, CMD_STATUS_RD, 8'h00);
		check("busy low", {7'h0, rd[7]}, 8'h00);
		delay = 8'h04;
		loc_cmp = 4'b1010;
		rem_cmp = 4'b0111;
		pair();
		access(1'b0, CMD_STATUS_RD, 8'h00);
		check("status flags", rd, 8'h4f);
		foreach (pin_cfg[i]) begin
			access(1'b1, CMD_CFG_WR, pin_cfg[i]);
			pins(pin_cfg[i], 8'h4f);
		end
		access(1'b1, CMD_CFG_WR, 8'h40);
		loc_cmp = 4'b0000;
		rem_cmp = 4'b0001;
		pair();
		access(1'b0, CMD_STATUS_RD, 8'h00);
		check("open only", rd, 8'h04);
		pins(8'h40, 8'h04);
		access(1'b1, CMD_CFG_WR, 8'h41);
		rem_cmp = 4'b1000;
		for (int i = 0; i < 3; i++) begin
			pair();
			access(1'b0, CMD_STATUS_RD, 8'h00);
			c = (i == 2) ? 8'h10 : 8'h00;
			check("queued over", rd, c);
			pins(8'h41, c);
		end
		complete_run();
	end
endmodule
